/* src/motor_fault_defines.svh */
// Offsets, field positions, reset values and timing figures of the fault control registers
`ifndef MOTOR_FAULT_DEFINES_SVH
`define MOTOR_FAULT_DEFINES_SVH

// ==========================================================
// Register offsets
`define ADDR_W                8
`define ADDR_FAULT_STATUS     8'h00
`define ADDR_DIAG_STATUS      8'h01
`define ADDR_FAULT_RESPONSE   8'h03
`define ADDR_LOCK_OUTPUT      8'h04
`define ADDR_DIAG_REGULATION  8'h05

// ==========================================================
// Fault response control fields
`define FRC_TRIP_REP          7
`define FRC_OT_RECOVERY       6
`define FRC_WARN_REP          5
`define FRC_PUMP_UV_DIS       4
`define FRC_RETRY_HI          3
`define FRC_RETRY_LO          2
`define FRC_OCP_HI            1
`define FRC_OCP_LO            0
`define FRC_RESET             8'h0C

// ==========================================================
// Lock and output control fields
`define LOC_FAULT_CLEAR       7
`define LOC_LOCK_HI           6
`define LOC_LOCK_LO           4
`define LOC_HB_ONE_OFF        3
`define LOC_HB_TWO_OFF        2
`define LOC_SOFT_A            1
`define LOC_SOFT_B            0
`define LOCK_KEY              3'h3
`define UNLOCK_KEY            3'h4
`define LOC_LOW_RESET         4'h0

// ==========================================================
// Diagnostic and regulation control fields
`define DRC_RSVD              7
`define DRC_OL_RUN            6
`define DRC_OL_DELAY          5
`define DRC_OL_ACTIVE         4
`define DRC_LEVEL_HI          3
`define DRC_LEVEL_LO          2
`define DRC_REG_OFF_HI        1
`define DRC_REG_OFF_LO        0
`define DRC_RESET             8'h08

// ==========================================================
// Timing
`define CLK_MHZ               200
`define OL_DELAY_SHORT_US     300
`define OL_DELAY_LONG_US      1200
`define RETRY_BASE_US         500
`define TIMER_W               20

`endif

/* src/motor_fault_pkg.sv */
// Types shared by the motor driver fault control logic
package motor_fault_pkg;

   // ==========================================================
   // Bridge input modes
   typedef enum logic [1:0] {
      MODE_PHASE_ENABLE,
      MODE_PWM,
      MODE_HALF_BRIDGE,
      MODE_INPUTS_OFF
   } bridge_mode_t;

   // ==========================================================
   // Overcurrent responses
   typedef enum logic [1:0] {
      OCP_LATCHED,
      OCP_RETRY,
      OCP_REPORT_ONLY,
      OCP_IGNORED
   } ocp_response_t;

endpackage

/* src/input_sync.sv */
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps

module input_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* src/fault_timer.sv */
// One-shot down counter that pulses done when a loaded wait runs out
`timescale 1ns/1ps

module fault_timer #(
   parameter int unsigned WIDTH = 20
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // Status
   output logic                  busy,
   output logic                  done
);

   logic [WIDTH-1:0] count_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else if (load) begin
         count_q <= load_value;
         busy    <= 1'b1;
         done    <= 1'b0;
      end else if (busy && count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
         count_q <= '0;
         busy    <= 1'b0;
         done    <= 1'b1;
      end else begin
         count_q <= busy ? count_q - {{(WIDTH-1){1'b0}}, 1'b1} : count_q;
         done    <= 1'b0;
      end
   end

endmodule

/* src/motor_driver_fault_control_regs.sv */
// Fault response, lock, output and diagnostic control registers of an H-bridge driver
// Function
// - Trip report bit routes regulation trips onto fault output and global flag.
// - Overtemperature bit selects latched shutdown or automatic recovery.
// - Warning report bit routes overtemperature warning onto fault output and flag.
// - Pump undervoltage disable bit makes charge pump undervoltage ignored.
// - Retry field picks overcurrent retry wait of 0.5, 1, 2 or 4 ms.
// - Overcurrent field picks latched, retrying, report only or ignored.
// - Writing one to fault clear clears latched faults; bit self-clears.
// - Lock key 011b freezes settings; 100b unlocks; lock and clear stay writable.
// - Half-bridge off bits act only in independent half-bridge mode.
// - Software input bits replace input pins while software drive selected.
// - Writing one starts standby open-load test; bit clears when test ends.
// - Open-load delay bit selects 300 us or 1.2 ms.
// - Active open-load enable turns open-load checks on during operation.
// - Level field picks trip current; disable field turns regulation off per output.
// - Soft-drive select routes outputs from pins or software bits.
// - Bridge mode code 10b is independent half-bridge; 11b is high impedance.
// - Global fault status bit mirrors the fault output pin.
`timescale 1ns/1ps
`include "motor_fault_defines.svh"

module motor_driver_fault_control_regs #(
   parameter int unsigned TIMER_W           = `TIMER_W,
   parameter int unsigned RETRY_BASE_CYCLES = `RETRY_BASE_US * `CLK_MHZ,
   parameter int unsigned OL_SHORT_CYCLES   = `OL_DELAY_SHORT_US * `CLK_MHZ,
   parameter int unsigned OL_LONG_CYCLES    = `OL_DELAY_LONG_US * `CLK_MHZ
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Register access
   input  wire logic                          reg_wr_en,
   input  wire logic                          reg_rd_en,
   input  wire logic [`ADDR_W-1:0]            reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   // Settings from the first control register
   input  wire logic                          soft_drive_select,
   input  wire motor_fault_pkg::bridge_mode_t bridge_mode,
   input  wire logic                          standby_mode,
   // Asynchronous inputs from pins and analog sensors
   input  wire logic                          in_pin_a,
   input  wire logic                          in_pin_b,
   input  wire logic [1:0]                    current_trip_event,
   input  wire logic                          temperature_warning,
   input  wire logic                          overtemp_detect,
   input  wire logic                          pump_undervoltage,
   input  wire logic                          supply_undervoltage,
   input  wire logic                          overcurrent_detect,
   input  wire logic [1:0]                    open_load_detect,
   // Fault pin
   output logic                               fault_out_n,
   // Half-bridge drive
   output logic                               output_one,
   output logic                               output_two,
   output logic                               output_one_en,
   output logic                               output_two_en,
   // Analog settings and status
   output logic [1:0]                         regulation_level,
   output logic [1:0]                         regulation_disable,
   output logic                               openload_test_busy,
   output logic                               settings_locked
);

   import motor_fault_pkg::*;

   // ==========================================================
   // Input synchronisation
   localparam int unsigned SYNC_W = 11;

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic              pin_a_s;
   logic              pin_b_s;
   logic [1:0]        trip_s;
   logic              warn_s;
   logic              ot_s;
   logic              pump_uv_s;
   logic              supply_uv_s;
   logic              ocp_s;
   logic [1:0]        ol_s;

   assign raw_in = {in_pin_a, in_pin_b, current_trip_event, temperature_warning,
                    overtemp_detect, pump_undervoltage, supply_undervoltage,
                    overcurrent_detect, open_load_detect};
   assign {pin_a_s, pin_b_s, trip_s, warn_s, ot_s, pump_uv_s, supply_uv_s,
           ocp_s, ol_s} = sync_in;

   input_sync #(
      .WIDTH    (SYNC_W)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   // ==========================================================
   // Write decode
   function automatic logic hit(input logic [`ADDR_W-1:0] addr,
                                input logic [`ADDR_W-1:0] target);
      hit = (addr == target);
   endfunction

   logic wr_frc;
   logic wr_loc;
   logic wr_drc;
   logic locked;

   assign wr_frc = reg_wr_en && hit(reg_addr, `ADDR_FAULT_RESPONSE);
   assign wr_loc = reg_wr_en && hit(reg_addr, `ADDR_LOCK_OUTPUT);
   assign wr_drc = reg_wr_en && hit(reg_addr, `ADDR_DIAG_REGULATION);

   // ==========================================================
   // Lock field and fault clear pulse
   logic [2:0] lock_field_q;
   logic       fault_clear_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_field_q <= `UNLOCK_KEY;
      end else if (wr_loc && (reg_wdata[`LOC_LOCK_HI:`LOC_LOCK_LO] == `LOCK_KEY ||
                              reg_wdata[`LOC_LOCK_HI:`LOC_LOCK_LO] == `UNLOCK_KEY)) begin
         lock_field_q <= reg_wdata[`LOC_LOCK_HI:`LOC_LOCK_LO];
      end
   end

   assign locked = (lock_field_q == `LOCK_KEY);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_clear_q <= 1'b0;
      end else begin
         fault_clear_q <= wr_loc && reg_wdata[`LOC_FAULT_CLEAR];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         settings_locked <= 1'b0;
      end else begin
         settings_locked <= locked;
      end
   end

   // ==========================================================
   // Control registers
   logic [7:0] frc_q;
   logic [3:0] loc_low_q;
   logic [7:0] drc_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frc_q <= `FRC_RESET;
      end else if (wr_frc && !locked) begin
         frc_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loc_low_q <= `LOC_LOW_RESET;
      end else if (wr_loc && !locked) begin
         loc_low_q <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drc_q <= `DRC_RESET;
      end else if (wr_drc && !locked) begin
         drc_q <= {reg_wdata[`DRC_RSVD], 1'b0, reg_wdata[`DRC_OL_DELAY:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regulation_level   <= 2'(`DRC_RESET >> `DRC_LEVEL_LO);
         regulation_disable <= 2'h0;
      end else begin
         regulation_level   <= drc_q[`DRC_LEVEL_HI:`DRC_LEVEL_LO];
         regulation_disable <= drc_q[`DRC_REG_OFF_HI:`DRC_REG_OFF_LO];
      end
   end

   // ==========================================================
   // Standby open-load test
   logic               ol_run_q;
   logic               ol_start;
   logic               ol_done;
   logic [TIMER_W-1:0] ol_wait;

   assign ol_start = wr_drc && !locked && reg_wdata[`DRC_OL_RUN] && standby_mode && !ol_run_q;
   // Delay taken from the starting write itself
   assign ol_wait  = reg_wdata[`DRC_OL_DELAY] ? TIMER_W'(OL_LONG_CYCLES)
                                              : TIMER_W'(OL_SHORT_CYCLES);

   fault_timer #(
      .WIDTH      (TIMER_W)
   ) u_ol_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .load       (ol_start),
      .load_value (ol_wait),
      .busy       (),
      .done       (ol_done)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ol_run_q <= 1'b0;
      end else if (ol_start) begin
         ol_run_q <= 1'b1;
      end else if (ol_done) begin
         ol_run_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         openload_test_busy <= 1'b0;
      end else begin
         openload_test_busy <= ol_start || (ol_run_q && !ol_done);
      end
   end

   // ==========================================================
   // Fault detection and latching
   ocp_response_t overcurrent_response;
   logic          ocp_prev_q;
   logic          ocp_rise;
   logic          retry_done;
   logic [TIMER_W-1:0] retry_wait;
   logic          ocp_stat_q;
   logic          ocp_hold_q;
   logic          tsd_q;
   logic          uvlo_q;
   logic          cpuv_q;
   logic          otw_q;
   logic [1:0]    ol_flag_q;
   logic [1:0]    ol_seen;
   logic [1:0]    trip_eff;
   logic          pump_fault;
   logic          fault_any;

   assign overcurrent_response   = ocp_response_t'(frc_q[`FRC_OCP_HI:`FRC_OCP_LO]);
   assign ocp_rise   = ocp_s && !ocp_prev_q;
   assign retry_wait = TIMER_W'(RETRY_BASE_CYCLES) << frc_q[`FRC_RETRY_HI:`FRC_RETRY_LO];
   assign pump_fault = pump_uv_s && !frc_q[`FRC_PUMP_UV_DIS];
   assign trip_eff   = trip_s & ~drc_q[`DRC_REG_OFF_HI:`DRC_REG_OFF_LO];
   assign ol_seen    = ol_s & {2{ol_done || (drc_q[`DRC_OL_ACTIVE] && !standby_mode)}};

   fault_timer #(
      .WIDTH      (TIMER_W)
   ) u_retry_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .load       (ocp_rise && overcurrent_response == OCP_RETRY),
      .load_value (retry_wait),
      .busy       (),
      .done       (retry_done)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ocp_prev_q <= 1'b0;
         ocp_stat_q <= 1'b0;
      end else begin
         ocp_prev_q <= ocp_s;
         ocp_stat_q <= (ocp_rise && overcurrent_response != OCP_IGNORED) ||
                       (ocp_stat_q && !fault_clear_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ocp_hold_q <= 1'b0;
      end else begin
         unique case (overcurrent_response)
            OCP_LATCHED: begin
               ocp_hold_q <= ocp_rise || (ocp_hold_q && !fault_clear_q);
            end
            OCP_RETRY: begin
               ocp_hold_q <= ocp_rise || (ocp_hold_q && !retry_done);
            end
            OCP_REPORT_ONLY, OCP_IGNORED: begin
               ocp_hold_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tsd_q <= 1'b0;
      end else if (frc_q[`FRC_OT_RECOVERY]) begin
         tsd_q <= ot_s;
      end else begin
         tsd_q <= ot_s || (tsd_q && !fault_clear_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         uvlo_q    <= 1'b0;
         cpuv_q    <= 1'b0;
         otw_q     <= 1'b0;
         ol_flag_q <= 2'h0;
      end else begin
         uvlo_q    <= supply_uv_s || (uvlo_q && !fault_clear_q);
         cpuv_q    <= pump_fault || (cpuv_q && !fault_clear_q);
         otw_q     <= warn_s || (otw_q && !fault_clear_q);
         ol_flag_q <= ol_seen | (ol_flag_q & {2{!fault_clear_q}});
      end
   end

   assign fault_any = tsd_q || uvlo_q || (cpuv_q && !frc_q[`FRC_PUMP_UV_DIS]) || ocp_stat_q ||
                      (|ol_flag_q) ||
                      (otw_q && frc_q[`FRC_WARN_REP]) ||
                      ((|trip_eff) && frc_q[`FRC_TRIP_REP]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_out_n <= 1'b1;
      end else begin
         fault_out_n <= !fault_any;
      end
   end

   // ==========================================================
   // Half-bridge drive
   logic drive_a;
   logic drive_b;
   logic drive_block;
   logic one_d;
   logic two_d;
   logic one_en_d;
   logic two_en_d;

   assign drive_a     = soft_drive_select ? loc_low_q[`LOC_SOFT_A] : pin_a_s;
   assign drive_b     = soft_drive_select ? loc_low_q[`LOC_SOFT_B] : pin_b_s;
   assign drive_block = tsd_q || supply_uv_s || pump_fault || ocp_hold_q;

   always_comb begin
      one_d    = 1'b0;
      two_d    = 1'b0;
      one_en_d = 1'b0;
      two_en_d = 1'b0;
      unique case (bridge_mode)
         MODE_PHASE_ENABLE: begin
            one_d    = drive_a && drive_b;
            two_d    = drive_a && !drive_b;
            one_en_d = 1'b1;
            two_en_d = 1'b1;
         end
         MODE_PWM: begin
            one_d    = drive_a;
            two_d    = drive_b;
            one_en_d = 1'b1;
            two_en_d = 1'b1;
         end
         MODE_HALF_BRIDGE: begin
            one_d    = drive_a;
            two_d    = drive_b;
            one_en_d = !loc_low_q[`LOC_HB_ONE_OFF];
            two_en_d = !loc_low_q[`LOC_HB_TWO_OFF];
         end
         MODE_INPUTS_OFF: begin
            one_en_d = 1'b0;
            two_en_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         output_one    <= 1'b0;
         output_two    <= 1'b0;
         output_one_en <= 1'b0;
         output_two_en <= 1'b0;
      end else begin
         output_one    <= one_d;
         output_two    <= two_d;
         output_one_en <= one_en_d && !drive_block;
         output_two_en <= two_en_d && !drive_block;
      end
   end

   // ==========================================================
   // Read port
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (hit(reg_addr, `ADDR_FAULT_STATUS)) begin
         rd_mux = {1'b0, !fault_out_n, otw_q, uvlo_q, cpuv_q, ocp_stat_q, tsd_q,
                   |ol_flag_q};
      end else if (hit(reg_addr, `ADDR_DIAG_STATUS)) begin
         rd_mux = {ol_flag_q, trip_eff[0], trip_eff[1], 4'h0};
      end else if (hit(reg_addr, `ADDR_FAULT_RESPONSE)) begin
         rd_mux = frc_q;
      end else if (hit(reg_addr, `ADDR_LOCK_OUTPUT)) begin
         rd_mux = {1'b0, lock_field_q, loc_low_q};
      end else if (hit(reg_addr, `ADDR_DIAG_REGULATION)) begin
         rd_mux = {drc_q[`DRC_RSVD], ol_run_q, drc_q[`DRC_OL_DELAY:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata <= rd_mux;
      end
   end

endmodule

/* verification/fault_regs_sva.sv */
// Port checker for the fault control register block
`timescale 1ns/1ps
`include "motor_fault_defines.svh"
module fault_regs_sva (
   // Clock, reset and register access
   input wire logic                          clk,
   input wire logic                          rst_n,
   input wire logic                          reg_wr_en,
   input wire logic                          reg_rd_en,
   input wire logic [7:0]                    reg_addr,
   input wire logic [7:0]                    reg_wdata,
   input wire logic [7:0]                    reg_rdata,
   // Mode and outputs
   input wire motor_fault_pkg::bridge_mode_t bridge_mode,
   input wire logic                          fault_out_n,
   input wire logic                          output_one_en,
   input wire logic                          output_two_en,
   input wire logic [1:0]                    regulation_level,
   input wire logic [1:0]                    regulation_disable,
   input wire logic                          openload_test_busy,
   input wire logic                          settings_locked
);
   import motor_fault_pkg::*;
   wire wr04 = reg_wr_en && reg_addr == `ADDR_LOCK_OUTPUT;
   wire wr05 = reg_wr_en && reg_addr == `ADDR_DIAG_REGULATION;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Assertions
   a_lock_raises:
      assert property (wr04 && reg_wdata[6:4] == `LOCK_KEY |-> ##2 settings_locked)
         else $error("lock flag not raised");
   a_unlock_drops:
      assert property (wr04 && reg_wdata[6:4] == `UNLOCK_KEY |-> ##2 !settings_locked)
         else $error("lock flag not dropped");
   a_level_follows:
      assert property (wr05 ##1 !settings_locked |->
         ##1 {regulation_level, regulation_disable} == 4'($past(reg_wdata, 2)))
         else $error("regulation fields not updated");
   a_level_frozen:
      assert property (wr05 ##1 settings_locked |->
         ##1 $stable({regulation_level, regulation_disable}))
         else $error("locked regulation fields changed");
   a_flag_mirror:
      assert property (reg_rd_en && reg_addr == `ADDR_FAULT_STATUS |=>
         reg_rdata[6] == !$past(fault_out_n))
         else $error("global fault bit differs from pin");
   a_clear_self:
      assert property (reg_rd_en && reg_addr == `ADDR_LOCK_OUTPUT |=> !reg_rdata[7])
         else $error("fault clear bit reads one");
   a_test_ends:
      assert property ($rose(openload_test_busy) |->
         openload_test_busy [*8] ##[1:40] !openload_test_busy)
         else $error("open-load test length wrong");
   a_hiz_off:
      assert property ($past(bridge_mode) == MODE_INPUTS_OFF |->
         !output_one_en && !output_two_en)
         else $error("bridge driven while inputs off");
endmodule
bind motor_driver_fault_control_regs fault_regs_sva chk (.*);

/* verification/reg_host.sv */
// Register host model issuing single-cycle read and write strobes
`timescale 1ns/1ps
module reg_host (
   // Clock
   input  wire logic       clk,
   // Register access
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Request held through the sampling edge, then released
   task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk);
      #1;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = ~d;
      q = reg_rdata;
   endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the fault control register block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import motor_fault_pkg::*;
   logic         clk, rst_n, reg_wr_en, reg_rd_en, soft_drive_select, standby_mode;
   logic         in_pin_a, in_pin_b, temperature_warning, overtemp_detect, pump_undervoltage;
   logic         supply_undervoltage, overcurrent_detect, fault_out_n, output_one;
   logic         output_two, output_one_en, output_two_en, openload_test_busy;
   logic         settings_locked;
   logic [1:0]   current_trip_event, open_load_detect, regulation_level, regulation_disable;
   logic [7:0]   reg_addr, reg_wdata, reg_rdata, q;
   logic [3:0]   drv;
   bridge_mode_t bridge_mode;
   int           num_errors, checked, cycles, n;
   assign drv = {output_one, output_two, output_one_en, output_two_en};
   always #2.5 clk = ~clk;
   motor_driver_fault_control_regs #(
      .RETRY_BASE_CYCLES(8), .OL_SHORT_CYCLES(20), .OL_LONG_CYCLES(40)) dut (.*);
   reg_host h (.*);
   // ==========================================================
   // Access and helper tasks
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      h.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, e);
      h.xfer(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   // Stale events must leave the synchronisers before the clear
   task automatic clr();
      cyc(4);
      wr(8'h04, 8'h80);
      cyc(5);
   endtask
   task automatic ocp_pulse();
      overcurrent_detect = 1'b1;
      cyc(3);
      overcurrent_detect = 1'b0;
   endtask
   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   // ==========================================================
   // Test sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {soft_drive_select, standby_mode, in_pin_a, in_pin_b, temperature_warning} = '0;
      {overtemp_detect, pump_undervoltage, supply_undervoltage, overcurrent_detect} = '0;
      current_trip_event = 2'h0;
      open_load_detect = 2'h0;
      bridge_mode = MODE_PWM;
      cyc(3);
      rst_n = 1'b1;
      rd(8'h03, 8'h0C);
      rd(8'h04, 8'h40);
      rd(8'h05, 8'h08);
      for (int i = 0; i < 4; i++) begin
         wr(8'h05, 8'(i * 5));
         cyc(2);
         `CHK({regulation_level, regulation_disable}, 4'(i * 5))
      end
      wr(8'h05, 8'h08);
      current_trip_event = 2'h1;
      temperature_warning = 1'b1;
      cyc(6);
      `CHK(fault_out_n, 1'b1)
      wr(8'h03, 8'h8C);
      cyc(4);
      `CHK(fault_out_n, 1'b0)
      rd(8'h00, 8'h60);
      wr(8'h03, 8'h2C);
      cyc(4);
      `CHK(fault_out_n, 1'b0)
      current_trip_event = 2'h0;
      temperature_warning = 1'b0;
      clr();
      `CHK(fault_out_n, 1'b1)
      rd(8'h00, 8'h00);
      wr(8'h03, 8'h0C);
      overtemp_detect = 1'b1;
      cyc(4);
      overtemp_detect = 1'b0;
      cyc(9);
      `CHK(fault_out_n, 1'b0)
      clr();
      `CHK(fault_out_n, 1'b1)
      wr(8'h03, 8'h4C);
      overtemp_detect = 1'b1;
      cyc(4);
      overtemp_detect = 1'b0;
      cyc(9);
      `CHK(fault_out_n, 1'b1)
      wr(8'h03, 8'h1C);
      pump_undervoltage = 1'b1;
      cyc(6);
      `CHK(fault_out_n, 1'b1)
      wr(8'h03, 8'h0C);
      cyc(4);
      rd(8'h00, 8'h48);
      pump_undervoltage = 1'b0;
      clr();
      in_pin_a = 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h03, 8'(c * 4 + 1));
         cyc(4);
         ocp_pulse();
         cyc(2);
         `CHK(output_one_en, 1'b0)
         cyc((8 << c) - 4);
         `CHK(output_one_en, 1'b0)
         cyc(12);
         `CHK(output_one_en, 1'b1)
         clr();
      end
      wr(8'h03, 8'h0C);
      ocp_pulse();
      cyc(80);
      `CHK(output_one_en, 1'b0)
      clr();
      `CHK(output_one_en, 1'b1)
      wr(8'h03, 8'h0E);
      ocp_pulse();
      cyc(5);
      `CHK(output_one_en, 1'b1)
      rd(8'h00, 8'h44);
      clr();
      wr(8'h03, 8'h0F);
      ocp_pulse();
      cyc(5);
      rd(8'h00, 8'h00);
      wr(8'h04, 8'h30);
      cyc(2);
      `CHK(settings_locked, 1'b1)
      wr(8'h03, 8'hFF);
      wr(8'h05, 8'h03);
      rd(8'h03, 8'h0F);
      rd(8'h05, 8'h08);
      wr(8'h04, 8'h4F);
      rd(8'h04, 8'h40);
      wr(8'h03, 8'h0C);
      rd(8'h03, 8'h0C);
      wr(8'h05, 8'h08);
      in_pin_a = 1'b0;
      in_pin_b = 1'b1;
      soft_drive_select = 1'b1;
      bridge_mode = MODE_HALF_BRIDGE;
      wr(8'h04, 8'h4A);
      cyc(3);
      `CHK({output_two, output_one_en, output_two_en}, 3'h1)
      wr(8'h04, 8'h42);
      cyc(3);
      `CHK(drv, 4'hB)
      bridge_mode = MODE_PWM;
      wr(8'h04, 8'h4D);
      cyc(3);
      `CHK(drv, 4'h7)
      bridge_mode = MODE_PHASE_ENABLE;
      wr(8'h04, 8'h43);
      cyc(3);
      `CHK(drv, 4'hB)
      bridge_mode = MODE_INPUTS_OFF;
      cyc(3);
      `CHK(drv[1:0], 2'h0)
      bridge_mode = MODE_PWM;
      soft_drive_select = 1'b0;
      cyc(5);
      `CHK(drv[3:2], 2'h1)
      standby_mode = 1'b1;
      open_load_detect = 2'h2;
      for (int d = 0; d < 2; d++) begin
         wr(8'h05, 8'(8'h48 + d * 32));
         cyc(1);
         `CHK(openload_test_busy, 1'b1)
         n = 0;
         while (openload_test_busy === 1'b1 && n < 300) begin
            cyc(1);
            n++;
         end
         `CHK(n > (d ? 32 : 12) && n < (d ? 45 : 25), 1'b1)
         rd(8'h05, 8'(8'h08 + d * 32));
         rd(8'h01, 8'h80);
         clr();
      end
      standby_mode = 1'b0;
      open_load_detect = 2'h1;
      cyc(4);
      rd(8'h01, 8'h00);
      wr(8'h05, 8'h18);
      cyc(4);
      rd(8'h01, 8'h40);
      final_report();
   end
endmodule
